// [src/amr_defs.svh]
// Constants of the monitor read-out block and its bus master.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef AMR_DEFS_SVH
`define AMR_DEFS_SVH
// Bus addresses and mode codes
`define AMR_ARA_ADDR      7'h0C
`define AMR_SCAN_MONITOR  2'h2
`define AMR_RB_SELECT     2'h3
// Setup and configuration byte fields
`define AMR_SETUP_FLAG    7
`define AMR_SETUP_BIP     2
`define AMR_SETUP_MON     0
`define AMR_CFG_SCAN      6:5
`define AMR_CFG_RBSEL     4:3
`define AMR_CFG_LIMIT     2:1
`define AMR_CFG_SE        0
// Read-out fill patterns
`define AMR_RB_LEAD       4'hF
`define AMR_WORD_LEAD     6'h3F
// Reset values
`define AMR_HI_RESET      10'h3FF
`define AMR_SE_RESET      1'b1
// Host register offsets
`define AMR_REG_CMD       8'h00
`define AMR_REG_TXD       8'h04
`define AMR_REG_STAT      8'h08
`define AMR_REG_RXD       8'h0C
// Host command bits
`define AMR_CMD_START     0
`define AMR_CMD_STOP      1
`define AMR_CMD_WRITE     2
`define AMR_CMD_READ      3
`define AMR_CMD_NACK      4
// Link timing
`define AMR_CLK_PERIOD_NS 4
`define AMR_SCL_PERIOD_NS 2500
`define AMR_QTR_CYC       (`AMR_SCL_PERIOD_NS / (4 * `AMR_CLK_PERIOD_NS))
`endif

// [src/amr_pkg.sv]
// Types of the monitor read-out block and its bus master.
// Assumes nothing beyond the constants header.
package amr_pkg;
	typedef enum logic [5:0] {
		D_IDLE = 6'h01, D_ADDR = 6'h02, D_WACK = 6'h04,
		D_WRX  = 6'h08, D_RTX  = 6'h10, D_RACK = 6'h20
	} amr_dst_t;
	typedef enum logic [3:0] {
		H_IDLE = 4'h1, H_START = 4'h2, H_STOP = 4'h4, H_XFER = 4'h8
	} amr_hst_t;
	typedef struct packed {
		amr_dst_t        st;
		logic            scl_d, sda_d;
		logic [3:0]      bitc;
		logic [7:0]      sh;
		logic            rw, ara, ackd, fresh, reading, served;
		logic            sda_oe, int_oe, run, wm, mfirst;
		logic [1:0]      sec, ent, ph;
		logic [1:0]      scan, rbsel, lim;
		logic            se, bip, int_en;
		logic [2:0]      delay;
		logic [7:0]      alarm;
		logic [3:0][9:0] lo, hi, fault, cur;
	} amr_dev_state_t;
	typedef struct packed {
		amr_hst_t    st;
		logic [15:0] div;
		logic [1:0]  q;
		logic [3:0]  bitn, pend;
		logic [7:0]  txd, tx, rx;
		logic        nack_cmd, nack_rx, scl, sda_oe;
		logic [31:0] prdata;
		logic        pready, pslverr;
	} amr_host_state_t;
endpackage

// [src/amr_link_if.sv]
// Two-wire link between the host master and the monitor device.
// Assumes pull-ups: a wire is low while any enabled driver drives low.
`timescale 1ns/100ps
`default_nettype none
interface amr_link_if;
	logic scl;
	logic host_sda_o, host_sda_oe;
	logic dev_sda_o, dev_sda_oe;
	logic dev_int_o, dev_int_oe;
	logic sda, int_n;
	// Open-drain resolution
	assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);
	assign int_n = ~(dev_int_oe & ~dev_int_o);
	modport dev (input scl, sda, output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe);
	modport host (output scl, host_sda_o, host_sda_oe, input sda, int_n);
endinterface
`default_nettype wire

// [src/amr_sync.sv]
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes the inputs may change at any time.
`timescale 1ns/100ps
`default_nettype none
module amr_sync #(parameter int W = 2)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Pins in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	// Two stages, idle-high reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta_r <= '1;
			q <= '1;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// [src/amr_dev.sv]
// Monitor device end: two-wire slave with readback, monitor read-out,
// alarm window, fault snapshots and alert response.
// Assumes conversions arrive from a converter core on CLK.
`include "amr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module amr_dev
(
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RESET,
	// Two-wire link
	amr_link_if.dev         LINK,
	// Own address and converter results
	input  wire logic [6:0] SLAVE_ADDR,
	input  wire logic       CONV_VALID,
	input  wire logic [1:0] CONV_CHAN,
	input  wire logic [9:0] CONV_DATA,
	// Monitor state towards the converter
	output logic            MONITOR_RUN,
	output logic      [2:0] SCAN_DELAY,
	output logic            BIPOLAR
);
	amr_pkg::amr_dev_state_t s_r, s_nxt;
	logic [1:0] pin_q;
	logic       scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
	logic       rb, above, below;
	logic [1:0] ent_ch, n_last, ph_last;
	logic [2:0] up_i;
	logic [7:0] rd_byte, wb, alm_set;
	logic [9:0] word;

	// Pin synchroniser
	amr_sync #(.W(2)) u_sync (
		.clk   (CLK),
		.reset (RESET),
		.d     ({LINK.scl, LINK.sda}),
		.q     (pin_q)
	);
	assign scl_s = pin_q[1];
	assign sda_s = pin_q[0];

	// Byte served at the current read pointer
	always_comb
	begin
		rb = (s_r.rbsel == `AMR_RB_SELECT);
		ent_ch = s_r.se ? s_r.ent : {s_r.ent[0], 1'b0};
		n_last = s_r.se ? s_r.lim : {1'b0, s_r.lim[1]};
		ph_last = rb ? 2'h2 : 2'h1;
		word = (s_r.sec == 2'h1) ? s_r.fault[ent_ch] : s_r.cur[ent_ch];
		if (s_r.ara)
			rd_byte = {SLAVE_ADDR, 1'b1};
		else if (rb)
		begin
			if (s_r.sec == 2'h0)
				rd_byte = {`AMR_RB_LEAD, s_r.delay, s_r.int_en};
			else if (s_r.ph == 2'h0)
				rd_byte = {2'h0, s_r.lo[ent_ch][9:4]};
			else if (s_r.ph == 2'h1)
				rd_byte = {s_r.lo[ent_ch][3:0], 2'h0, s_r.hi[ent_ch][9:8]};
			else
				rd_byte = s_r.hi[ent_ch][7:0];
		end
		else if (s_r.sec == 2'h0)
			rd_byte = s_r.alarm;
		else if (s_r.ph == 2'h0)
			rd_byte = {`AMR_WORD_LEAD, word[9:8]};
		else
			rd_byte = word[7:0];
	end

	// Next state: window check, link slave, alarm flags
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.scl_d = scl_s;
		s_nxt.sda_d = sda_s;
		scl_rise = scl_s & ~s_r.scl_d;
		scl_fall = ~scl_s & s_r.scl_d;
		start_c = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
		stop_c = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;
		wb = {s_r.sh[6:0], sda_s};
		up_i = 3'h7 - {CONV_CHAN, 1'b0};
		alm_set = 8'h00;
		above = 1'b0;
		below = 1'b0;
		// Window comparison, paused while a monitor read runs
		if (CONV_VALID && s_r.scan == `AMR_SCAN_MONITOR && !s_r.reading)
		begin
			if (s_r.bip)
			begin
				above = $signed(CONV_DATA) > $signed(s_r.hi[CONV_CHAN]);
				below = $signed(CONV_DATA) < $signed(s_r.lo[CONV_CHAN]);
			end
			else
			begin
				above = CONV_DATA > s_r.hi[CONV_CHAN];
				below = CONV_DATA < s_r.lo[CONV_CHAN];
			end
			alm_set[up_i] = above;
			alm_set[up_i - 3'h1] = below;
			s_nxt.cur[CONV_CHAN] = CONV_DATA;
			if ((above || below) && s_r.alarm[up_i -: 2] == 2'h0)
				s_nxt.fault[CONV_CHAN] = CONV_DATA;
		end
		// Link slave
		if (stop_c)
		begin
			s_nxt.st = amr_pkg::D_IDLE;
			s_nxt.sda_oe = 1'b0;
			s_nxt.reading = 1'b0;
			s_nxt.wm = 1'b0;
			s_nxt.ara = 1'b0;
		end
		else if (start_c)
		begin
			s_nxt.st = amr_pkg::D_ADDR;
			s_nxt.bitc = 4'h0;
			s_nxt.sda_oe = 1'b0;
			s_nxt.reading = 1'b0;
			s_nxt.wm = 1'b0;
			s_nxt.ara = 1'b0;
		end
		else
		begin
			unique case (s_r.st)
				amr_pkg::D_IDLE: ;
				amr_pkg::D_ADDR:
					if (scl_rise)
					begin
						s_nxt.sh = wb;
						s_nxt.bitc = s_r.bitc + 4'h1;
						if (s_r.bitc == 4'h7)
						begin
							s_nxt.rw = sda_s;
							s_nxt.bitc = 4'h0;
							s_nxt.sec = 2'h0;
							s_nxt.ent = 2'h0;
							s_nxt.ph = 2'h0;
							s_nxt.st = amr_pkg::D_IDLE;
							if (s_r.sh[6:0] == SLAVE_ADDR)
							begin
								s_nxt.st = amr_pkg::D_WACK;
								s_nxt.reading = sda_s && !rb
									&& s_r.scan == `AMR_SCAN_MONITOR;
							end
							else if (s_r.sh[6:0] == `AMR_ARA_ADDR && sda_s && s_r.int_oe)
							begin
								s_nxt.st = amr_pkg::D_WACK;
								s_nxt.ara = 1'b1;
							end
						end
					end
				amr_pkg::D_WACK:
					if (scl_fall && !s_r.ackd)
					begin
						s_nxt.sda_oe = 1'b1;
						s_nxt.ackd = 1'b1;
					end
					else if (scl_fall)
					begin
						s_nxt.ackd = 1'b0;
						s_nxt.bitc = 4'h0;
						s_nxt.sh = rd_byte;
						s_nxt.sda_oe = s_r.rw & ~rd_byte[7];
						s_nxt.st = s_r.rw ? amr_pkg::D_RTX : amr_pkg::D_WRX;
					end
				amr_pkg::D_WRX:
					if (scl_rise)
					begin
						s_nxt.sh = wb;
						s_nxt.bitc = s_r.bitc + 4'h1;
						if (s_r.bitc == 4'h7)
						begin
							s_nxt.st = amr_pkg::D_WACK;
							s_nxt.bitc = 4'h0;
							if (!s_r.wm && wb[`AMR_SETUP_FLAG])
							begin
								s_nxt.bip = wb[`AMR_SETUP_BIP];
								s_nxt.wm = wb[`AMR_SETUP_MON];
								s_nxt.mfirst = 1'b1;
								s_nxt.sec = 2'h0;
								s_nxt.ent = 2'h0;
								s_nxt.ph = 2'h0;
							end
							else if (!s_r.wm)
							begin
								s_nxt.scan = wb[`AMR_CFG_SCAN];
								s_nxt.rbsel = wb[`AMR_CFG_RBSEL];
								s_nxt.lim = wb[`AMR_CFG_LIMIT];
								s_nxt.se = wb[`AMR_CFG_SE];
							end
							else if (s_r.mfirst)
							begin
								for (int i = 0; i < 4; i++)
									if (wb[7 - i])
										s_nxt.alarm[7 - 2 * i -: 2] = 2'h0;
								s_nxt.served = 1'b0;
								s_nxt.delay = wb[3:1];
								s_nxt.int_en = wb[0];
								s_nxt.mfirst = 1'b0;
							end
							else if (s_r.sec != 2'h3)
							begin
								// Threshold entry of the next scanned channel
								if (s_r.ph == 2'h0)
									s_nxt.lo[ent_ch][9:4] = wb[5:0];
								else if (s_r.ph == 2'h1)
								begin
									s_nxt.lo[ent_ch][3:0] = wb[7:4];
									s_nxt.hi[ent_ch][9:8] = wb[1:0];
								end
								else
									s_nxt.hi[ent_ch][7:0] = wb;
								s_nxt.ph = (s_r.ph == 2'h2) ? 2'h0 : s_r.ph + 2'h1;
								if (s_r.ph == 2'h2 && s_r.ent == n_last)
									s_nxt.sec = 2'h3;
								else if (s_r.ph == 2'h2)
									s_nxt.ent = s_r.ent + 2'h1;
							end
						end
					end
				amr_pkg::D_RTX:
					if (scl_rise)
					begin
						s_nxt.bitc = s_r.bitc + 4'h1;
						if (s_r.ara && !s_r.sda_oe && !sda_s)
						begin
							s_nxt.st = amr_pkg::D_IDLE;
							s_nxt.ara = 1'b0;
						end
						else if (s_r.bitc == 4'h7)
							s_nxt.st = amr_pkg::D_RACK;
					end
					else if (scl_fall && s_r.fresh)
					begin
						s_nxt.fresh = 1'b0;
						s_nxt.sh = rd_byte;
						s_nxt.sda_oe = ~rd_byte[7];
					end
					else if (scl_fall)
					begin
						s_nxt.sh = {s_r.sh[6:0], 1'b0};
						s_nxt.sda_oe = ~s_r.sh[6];
					end
				amr_pkg::D_RACK:
					if (scl_fall)
						s_nxt.sda_oe = 1'b0;
					else if (scl_rise && s_r.ara)
					begin
						s_nxt.served = 1'b1;
						s_nxt.ara = 1'b0;
						s_nxt.st = amr_pkg::D_IDLE;
					end
					else if (scl_rise && sda_s)
					begin
						s_nxt.st = amr_pkg::D_IDLE;
						s_nxt.reading = 1'b0;
					end
					else if (scl_rise)
					begin
						// Acknowledged: advance the read pointer
						s_nxt.st = amr_pkg::D_RTX;
						s_nxt.fresh = 1'b1;
						s_nxt.bitc = 4'h0;
						if (s_r.sec == 2'h0)
							s_nxt.sec = 2'h1;
						else if (s_r.ph != ph_last)
							s_nxt.ph = s_r.ph + 2'h1;
						else
						begin
							s_nxt.ph = 2'h0;
							s_nxt.ent = (s_r.ent == n_last) ? 2'h0 : s_r.ent + 2'h1;
							if (s_r.ent == n_last)
								s_nxt.sec = rb ? 2'h0 : 2'h2;
						end
					end
				default: s_nxt.st = amr_pkg::D_IDLE;
			endcase
		end
		// New alarms win over a clear in the same cycle
		if (|(alm_set & ~s_nxt.alarm))
			s_nxt.served = 1'b0;
		s_nxt.alarm = s_nxt.alarm | alm_set;
		s_nxt.int_oe = s_nxt.int_en & (|s_nxt.alarm) & ~s_nxt.served;
		s_nxt.run = (s_nxt.scan == `AMR_SCAN_MONITOR) & ~s_nxt.reading;
	end

	// State register
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			s_r <= '0;
			s_r.st <= amr_pkg::D_IDLE;
			s_r.scl_d <= 1'b1;
			s_r.sda_d <= 1'b1;
			s_r.se <= `AMR_SE_RESET;
			s_r.hi <= {4{`AMR_HI_RESET}};
		end
		else
			s_r <= s_nxt;
	end

	// Outputs
	assign MONITOR_RUN = s_r.run;
	assign SCAN_DELAY = s_r.delay;
	assign BIPOLAR = s_r.bip;
	assign LINK.dev_sda_o = 1'b0;
	assign LINK.dev_sda_oe = s_r.sda_oe;
	assign LINK.dev_int_o = 1'b0;
	assign LINK.dev_int_oe = s_r.int_oe;
endmodule
`default_nettype wire

// [src/amr_host.sv]
// Host end: APB-commanded two-wire master that makes SCL itself.
// Assumes software composes setup, threshold and alert sequences.
`include "amr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module amr_host #(parameter int QTR = `AMR_QTR_CYC)
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Two-wire link
	amr_link_if.host         LINK
);
	amr_pkg::amr_host_state_t s_r, s_nxt;
	logic [1:0] pin_q;
	logic       tick, acc, busy, ack_bit;

	// Pin synchroniser for data and interrupt
	amr_sync #(.W(2)) u_sync (
		.clk   (CLK),
		.reset (RESET),
		.d     ({LINK.sda, LINK.int_n}),
		.q     (pin_q)
	);

	// Next state: APB registers and bit engine
	always_comb
	begin
		s_nxt = s_r;
		busy = (s_r.st != amr_pkg::H_IDLE) || (s_r.pend != 4'h0);
		tick = (s_r.div == 16'(QTR - 1));
		acc = PSEL & PENABLE & s_r.pready;
		ack_bit = (s_r.bitn == 4'h8);
		// APB: answer one cycle after setup
		s_nxt.pready = PSEL & ~PENABLE & ~s_r.pready;
		if (PSEL && !PENABLE)
		begin
			s_nxt.pslverr = 1'b0;
			s_nxt.prdata = 32'h0000_0000;
			case (PADDR)
				`AMR_REG_CMD: ;
				`AMR_REG_TXD: s_nxt.prdata[7:0] = s_r.txd;
				`AMR_REG_STAT: s_nxt.prdata[2:0] = {~pin_q[0], s_r.nack_rx, busy};
				`AMR_REG_RXD: s_nxt.prdata[7:0] = s_r.rx;
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		if (acc && PWRITE && PADDR == `AMR_REG_TXD)
			s_nxt.txd = PWDATA[7:0];
		if (acc && PWRITE && PADDR == `AMR_REG_CMD && !busy)
		begin
			s_nxt.pend = PWDATA[3:0];
			s_nxt.nack_cmd = PWDATA[`AMR_CMD_NACK];
		end
		// Bit engine, quarter-period ticks
		s_nxt.div = (s_r.st == amr_pkg::H_IDLE || tick) ? 16'h0000 : s_r.div + 16'h0001;
		unique case (s_r.st)
			amr_pkg::H_IDLE:
				if (s_r.pend[`AMR_CMD_START])
				begin
					// Clock kept as is: a low clock rises in quarter 0
					s_nxt.st = amr_pkg::H_START;
					s_nxt.q = 2'h0;
					s_nxt.sda_oe = 1'b0;
				end
				else if (s_r.pend[`AMR_CMD_WRITE] || s_r.pend[`AMR_CMD_READ])
				begin
					s_nxt.st = amr_pkg::H_XFER;
					s_nxt.q = 2'h0;
					s_nxt.bitn = 4'h0;
					s_nxt.tx = s_r.txd;
					s_nxt.scl = 1'b0;
					s_nxt.sda_oe = s_r.pend[`AMR_CMD_WRITE] & ~s_r.txd[7];
				end
				else if (s_r.pend[`AMR_CMD_STOP])
				begin
					s_nxt.st = amr_pkg::H_STOP;
					s_nxt.q = 2'h0;
					s_nxt.scl = 1'b0;
					s_nxt.sda_oe = 1'b1;
				end
			amr_pkg::H_START:
				if (tick)
				begin
					s_nxt.q = s_r.q + 2'h1;
					s_nxt.scl = (s_r.q != 2'h3); // Only one fall, after the start
					s_nxt.sda_oe = (s_r.q != 2'h0);
					if (s_r.q == 2'h3)
					begin
						s_nxt.st = amr_pkg::H_IDLE;
						s_nxt.pend[`AMR_CMD_START] = 1'b0;
					end
				end
			amr_pkg::H_STOP:
				if (tick)
				begin
					s_nxt.q = s_r.q + 2'h1;
					s_nxt.scl = 1'b1;
					s_nxt.sda_oe = (s_r.q == 2'h0);
					if (s_r.q == 2'h3)
					begin
						s_nxt.st = amr_pkg::H_IDLE;
						s_nxt.pend[`AMR_CMD_STOP] = 1'b0;
					end
				end
			amr_pkg::H_XFER:
				if (tick)
				begin
					s_nxt.q = s_r.q + 2'h1;
					s_nxt.scl = (s_r.q == 2'h0) || (s_r.q == 2'h1);
					if (s_r.q == 2'h2 && !ack_bit)
						s_nxt.rx = {s_r.rx[6:0], pin_q[1]};
					if (s_r.q == 2'h2 && ack_bit)
						s_nxt.nack_rx = pin_q[1];
					if (s_r.q == 2'h3 && ack_bit)
					begin
						s_nxt.st = amr_pkg::H_IDLE;
						s_nxt.sda_oe = 1'b0;
						s_nxt.pend[`AMR_CMD_WRITE] = 1'b0;
						s_nxt.pend[`AMR_CMD_READ] = 1'b0;
					end
					else if (s_r.q == 2'h3)
					begin
						// Next bit, or the acknowledge slot
						s_nxt.bitn = s_r.bitn + 4'h1;
						s_nxt.tx = {s_r.tx[6:0], 1'b0};
						if (s_r.bitn == 4'h7)
							s_nxt.sda_oe = s_r.pend[`AMR_CMD_READ] & ~s_r.nack_cmd;
						else
							s_nxt.sda_oe = s_r.pend[`AMR_CMD_WRITE] & ~s_r.tx[6];
					end
				end
			default: s_nxt.st = amr_pkg::H_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			s_r <= '0;
			s_r.st <= amr_pkg::H_IDLE;
			s_r.scl <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs
	assign PRDATA = s_r.prdata;
	assign PREADY = s_r.pready;
	assign PSLVERR = s_r.pslverr;
	assign LINK.scl = s_r.scl;
	assign LINK.host_sda_o = 1'b0;
	assign LINK.host_sda_oe = s_r.sda_oe;
endmodule
`default_nettype wire

// [test/amr_link_assertions.sv]
// Concurrent checks on the two-wire link between host and device.
// Assumes the bench connects the link signals, CLK and RESET by name.
`timescale 1ns/100ps
`default_nettype none
module amr_link_assertions #(parameter int QTR = 8)
(
	// Clock and reset
	input  wire logic CLK,
	input  wire logic RESET,
	// Link wires and drivers
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic int_n,
	input  wire logic host_sda_oe,
	input  wire logic dev_sda_o,
	input  wire logic dev_sda_oe,
	input  wire logic dev_int_o,
	input  wire logic dev_int_oe
);
	logic        scl_q;
	logic        sda_q;
	logic [3:0]  rise_r;
	logic [15:0] run_r;
	logic        start_w;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	// Start condition: SDA falls while SCL stays high
	assign start_w = scl & scl_q & sda_q & ~sda;
	// Delayed levels, SCL rises since start, cycles since SCL moved
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			rise_r <= 4'h0;
			run_r <= 16'(QTR);
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			if (start_w)
				rise_r <= 4'h0;
			else if (scl & ~scl_q & (rise_r != 4'hF))
				rise_r <= rise_r + 4'h1;
			run_r <= (scl != scl_q) ? 16'h1 : ((run_r == 16'hFFFF) ? run_r : run_r + 16'h1);
		end
	end
	property p_int_wire;
		int_n == !dev_int_oe;
	endproperty
	a_int_wire: assert property (p_int_wire) else $error("interrupt level wrong");
	property p_sda_open_drain;
		dev_sda_o == 1'b0;
	endproperty
	a_sda_open_drain: assert property (p_sda_open_drain) else $error("data pin driven high");
	property p_int_open_drain;
		dev_int_o == 1'b0;
	endproperty
	a_int_open_drain: assert property (p_int_open_drain) else $error("int pin driven high");
	property p_dev_low_phase;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_dev_low_phase: assert property (p_dev_low_phase) else $error("device moved data, clk high");
	property p_start_host;
		start_w |-> host_sda_oe && !dev_sda_oe;
	endproperty
	a_start_host: assert property (p_start_host) else $error("start not made by host");
	property p_reset_quiet;
		$fell(RESET) |-> !dev_sda_oe && !dev_int_oe && scl;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("link busy after reset");
	property p_scl_quarter;
		(scl != scl_q) |-> run_r >= 16'(QTR);
	endproperty
	a_scl_quarter: assert property (p_scl_quarter) else $error("clock phase too short");
	property p_ack_after_addr;
		$rose(dev_sda_oe) |-> rise_r >= 4'h8;
	endproperty
	a_ack_after_addr: assert property (p_ack_after_addr) else $error("device drove before byte");
endmodule
`default_nettype wire

// [test/adc_monitor_readout_alert_tb.sv]
// Bench joining host and device over the link; drives APB and results.
// Assumes the host makes SCL from CLK with a short quarter period.
`include "amr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_monitor_readout_alert_tb;
	localparam int QTR = 8;
	logic        clk, reset, psel, penable, pwrite, cv, mrun, bip, pready, pslverr;
	logic [7:0]  paddr, st, rb;
	logic [31:0] pwdata, prdata;
	logic [2:0]  sdly;
	logic [1:0]  cch;
	logic [9:0]  cdat;
	int          bad_count, cmp_count;
	amr_link_if amr_link_if_inst ();
	amr_dev amr_dev_inst (.CLK(clk), .RESET(reset), .LINK(amr_link_if_inst.dev),
		.SLAVE_ADDR(7'h34), .CONV_VALID(cv), .CONV_CHAN(cch), .CONV_DATA(cdat),
		.MONITOR_RUN(mrun), .SCAN_DELAY(sdly), .BIPOLAR(bip));
	amr_host #(.QTR(QTR)) amr_host_inst (.CLK(clk), .RESET(reset), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .LINK(amr_link_if_inst.host));
	amr_link_assertions #(.QTR(QTR)) amr_link_assertions_inst (.CLK(clk), .RESET(reset),
		.scl(amr_link_if_inst.scl), .sda(amr_link_if_inst.sda), .int_n(amr_link_if_inst.int_n),
		.host_sda_oe(amr_link_if_inst.host_sda_oe), .dev_sda_o(amr_link_if_inst.dev_sda_o),
		.dev_sda_oe(amr_link_if_inst.dev_sda_oe), .dev_int_o(amr_link_if_inst.dev_int_o),
		.dev_int_oe(amr_link_if_inst.dev_int_oe));
	// Clock
	always #2 clk = ~clk;
	task automatic summarize();
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	// One APB transfer, held until PREADY is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge clk);
		end
		if (n == 50)
			bad_count++;
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One link command, waited out, then status and received byte
	task automatic xf(input logic [4:0] c, input logic [7:0] d);
		logic [31:0] r;
		int n;
		n = 0;
		apb(1'b1, `AMR_REG_TXD, {24'h0, d}, r);
		apb(1'b1, `AMR_REG_CMD, {27'h0, c}, r);
		repeat (2) @(posedge clk);
		apb(1'b0, `AMR_REG_STAT, 32'h0, r);
		while (r[0] !== 1'b0 && n < 1000)
		begin
			n++;
			apb(1'b0, `AMR_REG_STAT, 32'h0, r);
		end
		chk("busy", 32'h0, {31'h0, r[0]});
		st = r[7:0];
		apb(1'b0, `AMR_REG_RXD, 32'h0, r);
		rb = r[7:0];
	endtask
	// Write frame: start, bytes, stop, each acknowledged
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i])
		begin
			xf({3'b001, i == q.size() - 1, i == 0}, q[i]);
			chk("ack", 32'h0, {31'h0, st[1]});
		end
	endtask
	task automatic conv(input logic [1:0] c, input logic [9:0] d);
		@(posedge clk);
		cv <= 1'b1;
		cch <= c;
		cdat <= d;
		@(posedge clk);
		cv <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Read frame; negative entries are not compared
	task automatic rcv(input logic [7:0] a, input logic frz, input int e[$]);
		xf(5'h05, a);
		chk("ack", 32'h0, {31'h0, st[1]});
		if (frz)
		begin
			conv(2'h1, 10'h111);
			chk("run", 32'h0, {31'h0, mrun});
		end
		foreach (e[i])
		begin
			xf(i == e.size() - 1 ? 5'h1A : 5'h08, 8'h00);
			if (e[i] >= 0)
				chk("byte", 32'(e[i]), {24'h0, rb});
		end
	endtask
	task automatic t_reset();
		logic [31:0] r;
		chk("run", 32'h0, {31'h0, mrun});
		chk("int", 32'h1, {31'h0, amr_link_if_inst.int_n});
		apb(1'b0, 8'h10, 32'h0, r);
		chk("slverr", 32'h1, {31'h0, pslverr});
	endtask
	task automatic t_setup();
		send('{8'h68, 8'h43});
		send('{8'h68, 8'h81, 8'hFB, 8'h10, 8'h02, 8'h00, 8'h00, 8'h03, 8'hFF});
		chk("delay", 32'h5, {29'h0, sdly});
		chk("run", 32'h1, {31'h0, mrun});
		chk("bip", 32'h0, {31'h0, bip});
	endtask
	task automatic t_readback();
		send('{8'h68, 8'h1B});
		rcv(8'h69, 1'b0, '{'hFB, 'h10, 'h02, 'h00, 'h00, 'h03, 'hFF, 'hFB});
		send('{8'h68, 8'h43});
	endtask
	// Upper trip, then lower on same channel; read frozen and wrapped
	task automatic t_alarm();
		conv(2'h0, 10'h250);
		conv(2'h1, 10'h123);
		chk("int", 32'h0, {31'h0, amr_link_if_inst.int_n});
		conv(2'h0, 10'h050);
		rcv(8'h69, 1'b1, '{'hC0, 'hFE, 'h50, -1, -1, 'hFC, 'h50, 'hFD, 'h23, 'hFC, 'h50});
		chk("run", 32'h1, {31'h0, mrun});
	endtask
	task automatic t_alert();
		xf(5'h07, 8'h6A);
		chk("nack", 32'h1, {31'h0, st[1]});
		rcv(8'h19, 1'b0, '{'h69});
		chk("int", 32'h1, {31'h0, amr_link_if_inst.int_n});
	endtask
	task automatic t_clear();
		send('{8'h68, 8'h81, 8'h8B});
		chk("int", 32'h1, {31'h0, amr_link_if_inst.int_n});
		rcv(8'h69, 1'b0, '{'h00, 'hFE, 'h50});
		conv(2'h0, 10'h300);
		chk("int", 32'h0, {31'h0, amr_link_if_inst.int_n});
		send('{8'h68, 8'h85, 8'hFB, 8'h20, 8'h01, 8'hFF});
		chk("bip", 32'h1, {31'h0, bip});
		conv(2'h0, 10'h200);
		conv(2'h0, 10'h1FF);
		chk("int", 32'h1, {31'h0, amr_link_if_inst.int_n});
	endtask
	// Main sequence
	initial
	begin
		clk = 1'b0;
		reset = 1'b1;
		{psel, penable, pwrite, cv, paddr, pwdata, cch, cdat} = '0;
		bad_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset();
		t_setup();
		t_readback();
		t_alarm();
		t_alert();
		t_clear();
		summarize();
	end
	// Watchdog
	initial
	begin
		#300000;
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire
